//--- rtl/vtf_pkg.sv
// Purpose: shared constants and types of the vlan tagging filter
// Assumes: axi4-lite register map, 8 ports, 64 vlan table entries
// Notes: byte offsets are word aligned; the first entry is the default vlan
package vtf_pkg;
	// ***************************************************
	// sizes and vlan id limits
	// ***************************************************
	localparam int VTF_PORTS = 8;
	localparam int VTF_ENTRIES = 64;
	localparam logic [11:0] VTF_VID_MIN = 12'h001;
	localparam logic [11:0] VTF_VID_MAX = 12'hFFE;
	localparam logic [11:0] VTF_VID_DEFAULT = 12'h001;
	localparam logic [7:0] VTF_ALL_PORTS = 8'hFF;

	// ***************************************************
	// register offsets and fields
	// ***************************************************
	localparam logic [7:0] VTF_OFF_CTRL = 8'h00;
	localparam logic [7:0] VTF_OFF_TRUNK = 8'h04;
	localparam logic [7:0] VTF_OFF_TIDX = 8'h08;
	localparam logic [7:0] VTF_OFF_TVID = 8'h0C;
	localparam logic [7:0] VTF_OFF_TMASK = 8'h10;
	localparam logic [7:0] VTF_OFF_STATUS = 8'h14;
	localparam logic [2:0] VTF_PVID_PAGE = 3'h1;
	localparam int VTF_CTRL_MODE_BIT = 0;
	localparam int VTF_CTRL_MVID_LSB = 16;
	localparam int VTF_TVID_VALID_BIT = 31;
	localparam int VTF_TMASK_TAG_LSB = 0;
	localparam int VTF_TMASK_FORBID_LSB = 8;
	localparam int VTF_TMASK_GROUP_LSB = 16;
	localparam int VTF_STAT_CNT_LSB = 0;
	localparam int VTF_STAT_DROP_LSB = 16;
	localparam logic [1:0] VTF_RESP_OKAY = 2'h0;
	localparam logic [1:0] VTF_RESP_SLVERR = 2'h2;

	// ***************************************************
	// types
	// ***************************************************
	typedef enum logic {
		VTF_MODE_DOT1Q = 1'b0,
		VTF_MODE_PORT = 1'b1
	} vtf_mode_t;

	typedef struct packed {
		logic valid;
		logic [11:0] vid;
		logic [VTF_PORTS-1:0] tag;
		logic [VTF_PORTS-1:0] forbid;
		logic [VTF_PORTS-1:0] group;
	} vtf_entry_t;

	localparam vtf_entry_t VTF_ENTRY_DEFAULT = '{
		valid: 1'b1, vid: VTF_VID_DEFAULT, tag: 8'h00, forbid: 8'h00, group: VTF_ALL_PORTS};
endpackage

//--- rtl/vtf_match.sv
// Purpose: one vlan table entry compared against the frame's vlan
// Assumes: combinational, same clock domain as the table
// Notes: instantiated once per table entry
module vtf_match import vtf_pkg::*; (
	input wire vtf_entry_t entry,
	input wire logic [11:0] key_vid,
	input wire logic [11:0] mgmt_vid,
	input wire logic [2:0] port,
	output logic hit,
	output logic grp_hit,
	output logic mgmt_hit
);
	// entry matches the classified vid
	assign hit = entry.valid && (entry.vid == key_vid);
	// ingress port belongs to this port-based group
	assign grp_hit = entry.valid && entry.group[port];
	// the group carrying the management vid holds the ingress port
	assign mgmt_hit = grp_hit && (entry.vid == mgmt_vid);
endmodule

//--- rtl/vtf_filter.sv
// Purpose: per-port vlan classification, membership filter and egress tag plan
// Assumes: lookup requests come from logic on clk; registers over axi4-lite
// Notes: one lookup per cycle, answer one cycle later
// Operation
// - default vlan 1 holds all ports
// - management only reached on management vlan
// - never forward across vlans
// - access untagged gets pvid, tagged on trunk
// - trunk untagged frame gets trunk pvid
// - global mode select, 802.1q after reset
// - management vid 1..4094, resets to 1
// - port type access or trunk, resets access
// - per-port pvid 1..4094, resets to 1
// - tagged list empty, trunk only
// - forbidden list empty, blocks trunk, trunk only
// - port mode uses group membership, vlan1 default
// - at most 64 vlans, excess rejected
// - access egress strips the tag (802.1q mode only; port mode keeps the tag of a tagged frame on access egress)
// - trunk egress keeps the tag
// - only defined vlans are forwarded
module vtf_filter import vtf_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic lk_valid,
	input wire logic [2:0] lk_port,
	input wire logic lk_tagged,
	input wire logic [11:0] lk_vid,
	input wire logic lk_mgmt,
	output logic res_valid,
	output logic [11:0] res_vid,
	output logic [VTF_PORTS-1:0] res_fwd,
	output logic [VTF_PORTS-1:0] res_tag,
	output logic res_mgmt,
	output logic res_drop
);
	// ***************************************************
	// state
	// ***************************************************
	typedef struct packed {
		vtf_mode_t mode;
		logic [11:0] mgmt_vid;
		logic [VTF_PORTS-1:0] trunk;
		logic [VTF_PORTS-1:0][11:0] pvid;
		logic [5:0] idx;
		vtf_entry_t [VTF_ENTRIES-1:0] ent;
		logic [15:0] drops;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic res_valid;
		logic [11:0] res_vid;
		logic [VTF_PORTS-1:0] res_fwd;
		logic [VTF_PORTS-1:0] res_tag;
		logic res_mgmt;
		logic res_drop;
	} vtf_state_t;

	vtf_state_t s;
	vtf_state_t next_s;

	// ***************************************************
	// helpers
	// ***************************************************
	function automatic logic vid_ok(input logic [11:0] v);
		return (v >= VTF_VID_MIN) && (v <= VTF_VID_MAX);
	endfunction

	// read value of a register, top bit set when the address is mapped
	function automatic logic [32:0] rd_val(input vtf_state_t st, input logic [7:0] a);
		logic [31:0] d;
		logic ok;
		logic [6:0] cnt;
		d = '0;
		ok = 1'b1;
		cnt = '0;
		for (int i = 0; i < VTF_ENTRIES; i++) begin
			cnt = cnt + 7'(st.ent[i].valid);
		end
		case (a)
			VTF_OFF_CTRL: begin
				d[VTF_CTRL_MODE_BIT] = st.mode;
				d[VTF_CTRL_MVID_LSB +: 12] = st.mgmt_vid;
			end
			VTF_OFF_TRUNK: d[VTF_PORTS-1:0] = st.trunk;
			VTF_OFF_TIDX: d[5:0] = st.idx;
			VTF_OFF_TVID: begin
				d[VTF_TVID_VALID_BIT] = st.ent[st.idx].valid;
				d[11:0] = st.ent[st.idx].vid;
			end
			VTF_OFF_TMASK: begin
				d[VTF_TMASK_TAG_LSB +: VTF_PORTS] = st.ent[st.idx].tag;
				d[VTF_TMASK_FORBID_LSB +: VTF_PORTS] = st.ent[st.idx].forbid;
				d[VTF_TMASK_GROUP_LSB +: VTF_PORTS] = st.ent[st.idx].group;
			end
			VTF_OFF_STATUS: begin
				d[VTF_STAT_CNT_LSB +: 7] = cnt;
				d[VTF_STAT_DROP_LSB +: 16] = st.drops;
			end
			default: begin
				if (a[7:5] == VTF_PVID_PAGE && a[1:0] == 2'h0) begin
					d[11:0] = st.pvid[a[4:2]];
				end else begin
					ok = 1'b0;
				end
			end
		endcase
		return {ok, d};
	endfunction

	// byte lanes without a strobe keep the register's present value
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [32:0] wr_cur;
	logic [32:0] rd_cur;
	logic [31:0] wval;
	logic [11:0] pvid_in;
	logic in_trunk;
	logic [11:0] cls_vid;
	logic [VTF_ENTRIES-1:0] hit;
	logic [VTF_ENTRIES-1:0] grp_hit;
	logic [VTF_ENTRIES-1:0] mgmt_hit;

	assign wr_cur = rd_val(s, s.aw_addr);
	assign rd_cur = rd_val(s, s_axi_araddr);
	assign wval = merge(wr_cur[31:0], s.w_data, s.w_strb);

	// ***************************************************
	// ingress classification
	// ***************************************************
	assign pvid_in = s.pvid[lk_port];
	assign in_trunk = s.trunk[lk_port];
	// untagged and access frames take the port pvid
	assign cls_vid = (lk_tagged && in_trunk) ? lk_vid : pvid_in;

	// one comparator per table entry
	genvar g;
	generate
		for (g = 0; g < VTF_ENTRIES; g++) begin : gen_match
			vtf_match u_match (
				.entry(s.ent[g]),
				.key_vid(cls_vid),
				.mgmt_vid(s.mgmt_vid),
				.port(lk_port),
				.hit(hit[g]),
				.grp_hit(grp_hit[g]),
				.mgmt_hit(mgmt_hit[g])
			);
		end
	endgenerate

	// ***************************************************
	// next state
	// ***************************************************
	always_comb begin
		logic [VTF_PORTS-1:0] tag_or;
		logic [VTF_PORTS-1:0] fb_or;
		logic [VTF_PORTS-1:0] grp_or;
		logic [VTF_PORTS-1:0] memb;
		logic [VTF_PORTS-1:0] fwd;
		logic ok;
		tag_or = '0;
		fb_or = '0;
		grp_or = '0;
		memb = '0;
		fwd = '0;
		ok = 1'b0;
		next_s = s;
		next_s.res_valid = 1'b0;
		// address and data are taken independently, in either order
		if (s_axi_awvalid && !s.aw_have) begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_have) begin
			next_s.w_have = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		// a write commits once both halves are held and no response waits
		if (s.aw_have && s.w_have && !s.bvalid) begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = VTF_RESP_OKAY;
			case (s.aw_addr)
				VTF_OFF_CTRL: begin
					if (vid_ok(wval[VTF_CTRL_MVID_LSB +: 12])) begin
						next_s.mode = vtf_mode_t'(wval[VTF_CTRL_MODE_BIT]);
						next_s.mgmt_vid = wval[VTF_CTRL_MVID_LSB +: 12];
					end else begin
						next_s.bresp = VTF_RESP_SLVERR;
					end
				end
				// port type, set bit means trunk
				VTF_OFF_TRUNK: next_s.trunk = wval[VTF_PORTS-1:0];
				VTF_OFF_TIDX: begin
					// no entry beyond the 64th exists
					if (wval[31:6] == 26'h0) begin
						next_s.idx = wval[5:0];
					end else begin
						next_s.bresp = VTF_RESP_SLVERR;
					end
				end
				VTF_OFF_TVID: begin
					// a vlan is defined only with a legal vid
					if (!wval[VTF_TVID_VALID_BIT] || vid_ok(wval[11:0])) begin
						next_s.ent[s.idx].valid = wval[VTF_TVID_VALID_BIT];
						next_s.ent[s.idx].vid = wval[11:0];
					end else begin
						next_s.bresp = VTF_RESP_SLVERR;
					end
				end
				VTF_OFF_TMASK: begin
					next_s.ent[s.idx].tag = wval[VTF_TMASK_TAG_LSB +: VTF_PORTS];
					next_s.ent[s.idx].forbid = wval[VTF_TMASK_FORBID_LSB +: VTF_PORTS];
					next_s.ent[s.idx].group = wval[VTF_TMASK_GROUP_LSB +: VTF_PORTS];
				end
				VTF_OFF_STATUS: ; // read-only, write has no effect
				default: begin
					// pvid only within the legal range
					if (wr_cur[32] && vid_ok(wval[11:0])) begin
						next_s.pvid[s.aw_addr[4:2]] = wval[11:0];
					end else begin
						next_s.bresp = VTF_RESP_SLVERR;
					end
				end
			endcase
		end
		// reads answer in the cycle after the address is taken
		if (s_axi_arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_cur[32] ? rd_cur[31:0] : 32'h0000_0000;
			next_s.rresp = rd_cur[32] ? VTF_RESP_OKAY : VTF_RESP_SLVERR;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		// gather tag and forbidden lists of entries holding the classified vid, group lists of groups holding the port
		for (int i = 0; i < VTF_ENTRIES; i++) begin
			if (hit[i]) begin
				tag_or = tag_or | s.ent[i].tag;
				fb_or = fb_or | s.ent[i].forbid;
			end
			if (grp_hit[i]) begin
				grp_or = grp_or | s.ent[i].group;
			end
		end
		// lists only count on trunk ports
		for (int q = 0; q < VTF_PORTS; q++) begin
			memb[q] = s.trunk[q] ? (((s.pvid[q] == cls_vid) || tag_or[q]) && !fb_or[q])
				: (s.pvid[q] == cls_vid);
		end
		if (s.mode == VTF_MODE_DOT1Q) begin
			// defined vlan, member ingress, no foreign tag on access
			ok = (|hit) && memb[lk_port] && !(lk_tagged && !in_trunk && lk_vid != pvid_in);
			// only members of the same vlan receive the frame
			fwd = ok ? (memb & ~(8'h01 << lk_port)) : '0;
			// trunk egress carries the tag, access strips it
			next_s.res_tag = fwd & s.trunk;
			// management only on its own vlan
			next_s.res_mgmt = ok && lk_mgmt && (cls_vid == s.mgmt_vid);
		end else begin
			// port mode forwards within shared groups, tag untouched
			ok = |grp_hit;
			fwd = grp_or & ~(8'h01 << lk_port);
			next_s.res_tag = lk_tagged ? fwd : '0;
			next_s.res_mgmt = lk_mgmt && (|mgmt_hit);
		end
		if (lk_valid) begin
			next_s.res_valid = 1'b1;
			next_s.res_vid = cls_vid;
			next_s.res_fwd = fwd;
			next_s.res_drop = !ok;
			if (!ok && s.drops != 16'hFFFF) begin
				next_s.drops = s.drops + 16'h0001;
			end
		end
	end

	// register the whole state; reset builds the factory defaults
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
			s.ent[0] <= VTF_ENTRY_DEFAULT;
			s.mgmt_vid <= VTF_VID_DEFAULT;
			s.pvid <= {VTF_PORTS{VTF_VID_DEFAULT}};
		end else begin
			s <= next_s;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign s_axi_awready = !s.aw_have;
	assign s_axi_wready = !s.w_have;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign res_valid = s.res_valid;
	assign res_vid = s.res_vid;
	assign res_fwd = s.res_fwd;
	assign res_tag = s.res_tag;
	assign res_mgmt = s.res_mgmt;
	assign res_drop = s.res_drop;

	// ***************************************************
	// assertions
	// ***************************************************
	logic [VTF_PORTS-1:0] pv_ok;
	logic [VTF_PORTS-1:0] pv_eq;
	generate
		for (g = 0; g < VTF_PORTS; g++) begin : gen_chk
			assign pv_ok[g] = vid_ok(s.pvid[g]);
			assign pv_eq[g] = (s.pvid[g] == s.res_vid);
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence q_dot1q_req;
		lk_valid && s.mode == VTF_MODE_DOT1Q;
	endsequence
	sequence q_wr_go;
		s.aw_have && s.w_have && !s.bvalid;
	endsequence

	a_default_vlan: assert property (!$past(rstn) |-> s.ent[0].valid
		&& s.ent[0].vid == VTF_VID_DEFAULT && s.ent[0].group == VTF_ALL_PORTS)
		else $error("default vlan missing after reset");
	a_mgmt_vlan: assert property (s.res_valid && s.res_mgmt
		&& $past(s.mode) == VTF_MODE_DOT1Q
		|-> s.res_vid == $past(s.mgmt_vid) && !s.res_drop)
		else $error("management reached off its vlan");
	a_no_leak: assert property (s.res_valid && $past(s.mode) == VTF_MODE_DOT1Q
		&& $stable(s.trunk) && $stable(s.pvid)
		|-> (s.res_fwd & ~s.trunk & ~pv_eq) == '0 && !s.res_fwd[$past(lk_port)])
		else $error("frame forwarded into another vlan");
	a_acc_pvid: assert property (q_dot1q_req ##0 (!lk_tagged && !in_trunk)
		|=> s.res_vid == $past(pvid_in) && s.res_tag == (s.res_fwd & $past(s.trunk)))
		else $error("access frame not classified to pvid");
	a_trunk_pvid: assert property (q_dot1q_req ##0 (!lk_tagged && in_trunk)
		|=> s.res_valid && s.res_vid == $past(pvid_in))
		else $error("untagged trunk frame lost pvid");
	a_mode_reset: assert property (!$past(rstn) |-> s.mode == VTF_MODE_DOT1Q)
		else $error("mode not 802.1q after reset");
	a_mvid_range: assert property (vid_ok(s.mgmt_vid)
		and (!$past(rstn) |-> s.mgmt_vid == VTF_VID_DEFAULT))
		else $error("management vid out of range");
	a_type_reset: assert property (!$past(rstn) |-> s.trunk == '0)
		else $error("port not access after reset");
	a_pvid_range: assert property (&pv_ok)
		else $error("pvid out of range");
	a_tag_empty: assert property (!$past(rstn) |-> s.ent[0].tag == '0)
		else $error("tagged list not empty after reset");
	a_forbid_empty: assert property (!$past(rstn) |-> s.ent[0].forbid == '0)
		else $error("forbidden list not empty after reset");
	a_group_drop: assert property (lk_valid && s.mode == VTF_MODE_PORT
		&& !(|grp_hit) |=> s.res_drop && s.res_fwd == '0)
		else $error("port outside all groups forwarded");
	a_idx_limit: assert property (q_wr_go ##0 (s.aw_addr == VTF_OFF_TIDX
		&& wval[31:6] != 26'h0) |=> s.bvalid && s.bresp == VTF_RESP_SLVERR && $stable(s.idx))
		else $error("index beyond 64 accepted");
	a_acc_strip: assert property (s.res_valid && $past(s.mode) == VTF_MODE_DOT1Q
		|-> (s.res_tag & ~$past(s.trunk)) == '0)
		else $error("tag kept on access egress");
	a_trunk_keep: assert property (q_dot1q_req ##0 (lk_tagged && in_trunk)
		|=> s.res_vid == $past(lk_vid) && (s.res_fwd & $past(s.trunk)) == s.res_tag)
		else $error("tag lost on trunk egress");
	a_undef_drop: assert property (q_dot1q_req ##0 !(|hit)
		|=> s.res_valid && s.res_drop && s.res_fwd == '0)
		else $error("undefined vlan forwarded");
	a_acc_tag_drop: assert property (q_dot1q_req ##0 (lk_tagged && !in_trunk
		&& lk_vid != pvid_in) |=> s.res_drop && !s.res_mgmt)
		else $error("foreign tag on access port accepted");
endmodule

//--- tb/vtf_frame_src.sv
// Purpose: far-side frame source that presents lookups to the filter
// Assumes: one lookup per cycle at most, driven on the rising edge of clk
// Notes: between lookups the fields wander so stale values are never trusted
module vtf_frame_src (
	input wire logic clk,
	input wire logic rstn,
	input wire logic send,
	input wire logic [2:0] s_port,
	input wire logic s_tagged,
	input wire logic [11:0] s_vid,
	input wire logic s_mgmt,
	output logic lk_valid,
	output logic [2:0] lk_port,
	output logic lk_tagged,
	output logic [11:0] lk_vid,
	output logic lk_mgmt
);
	timeunit 1ns;
	timeprecision 1ns;

	// ***************************************************
	// frame presentation
	// ***************************************************
	// idle cycles invert the fields, so a design reading them late sees junk
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lk_valid <= 1'b0;
			lk_port <= 3'h0;
			lk_tagged <= 1'b0;
			lk_vid <= 12'h000;
			lk_mgmt <= 1'b0;
		end else if (send) begin
			lk_valid <= 1'b1;
			lk_port <= s_port;
			lk_tagged <= s_tagged;
			lk_vid <= s_vid;
			lk_mgmt <= s_mgmt;
		end else begin
			lk_valid <= 1'b0;
			lk_port <= ~lk_port;
			lk_tagged <= ~lk_tagged;
			lk_vid <= ~lk_vid;
			lk_mgmt <= ~lk_mgmt;
		end
	end
endmodule

//--- tb/vtf_filter_test.sv
// Purpose: self-checking bench of the vlan filter, registers and lookups
// Assumes: axi4-lite master tasks, frames from the far-side source model
// Notes: random lookups run back to back on the default configuration
module vtf_filter_test import vtf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic send = 1'b0, s_tagged = 1'b0, s_mgmt = 1'b0;
	logic [2:0] s_port = 3'h0;
	logic [11:0] s_vid = 12'h000;
	logic lk_valid, lk_tagged, lk_mgmt, res_valid, res_mgmt, res_drop;
	logic [2:0] lk_port;
	logic [11:0] lk_vid, res_vid;
	logic [7:0] res_fwd, res_tag;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'h1CC313D7;
	logic [31:0] exp_q [64];

	vtf_filter i_dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.lk_valid(lk_valid), .lk_port(lk_port), .lk_tagged(lk_tagged), .lk_vid(lk_vid),
		.lk_mgmt(lk_mgmt), .res_valid(res_valid), .res_vid(res_vid), .res_fwd(res_fwd),
		.res_tag(res_tag), .res_mgmt(res_mgmt), .res_drop(res_drop));
	vtf_frame_src i_src (.clk(clk), .rstn(rstn), .send(send), .s_port(s_port),
		.s_tagged(s_tagged), .s_vid(s_vid), .s_mgmt(s_mgmt), .lk_valid(lk_valid),
		.lk_port(lk_port), .lk_tagged(lk_tagged), .lk_vid(lk_vid), .lk_mgmt(lk_mgmt));

	initial begin
		forever #5 clk = ~clk;
	end

	// ***************************************************
	// helpers
	// ***************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// expected answer word: valid, drop, mgmt, tag, fwd, vid
	function automatic logic [31:0] pk(input logic d, m, input logic [7:0] t, f,
		input logic [11:0] v);
		return {2'b01, d, m, t, f, v};
	endfunction

	// default setup: all access, pvid 1, management vid 1
	function automatic logic [31:0] exp_def(input logic [2:0] p, input logic t, m,
		input logic [11:0] v);
		logic ok;
		ok = !(t && v != 12'h001);
		return pk(!ok, ok && m, 8'h00, ok ? (8'hFF & ~(8'h01 << p)) : 8'h00, 12'h001);
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a wait that runs out ends the run with a mismatch
	task automatic timed_out(input bit done);
		if (!done) begin
			fail_count++;
			tally_and_finish();
		end
	endtask

	// ***************************************************
	// bus and lookup tasks
	// ***************************************************
	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int k = 0; k < 100 && !done; k++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				check({30'h0, bresp}, {30'h0, er});
				bready <= 1'b0;
				done = 1;
			end
		end
		timed_out(done);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int k = 0; k < 100 && !done; k++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				check(rdata, ed);
				check({30'h0, rresp}, {30'h0, er});
				rready <= 1'b0;
				done = 1;
			end
		end
		timed_out(done);
	endtask

	task automatic lk(input logic [2:0] p, input logic t, m, input logic [11:0] v,
		input logic [31:0] e);
		@(posedge clk);
		send <= 1'b1;
		s_port <= p;
		s_tagged <= t;
		s_vid <= v;
		s_mgmt <= m;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
		#1;
		check({res_valid ? 2'b01 : 2'b00, res_drop, res_mgmt, res_tag, res_fwd, res_vid}, e);
	endtask

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
	endtask

	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		do_reset();
		rchk(VTF_OFF_CTRL, 32'h00010000, VTF_RESP_OKAY);
		rchk(VTF_OFF_TRUNK, 32'h00000000, VTF_RESP_OKAY);
		for (int p = 0; p < 8; p++) rchk(8'h20 + 8'(4 * p), 32'h1, VTF_RESP_OKAY);
		rchk(VTF_OFF_TVID, 32'h80000001, VTF_RESP_OKAY);
		rchk(VTF_OFF_TMASK, 32'h00FF0000, VTF_RESP_OKAY);
		rchk(VTF_OFF_STATUS, 32'h00000001, VTF_RESP_OKAY);
		lk(3'h3, 1'b0, 1'b1, 12'h000, pk(0, 1, 8'h00, 8'hF7, 12'h001));
		// refused values leave the registers alone
		wchk(8'h18, 32'h1, VTF_RESP_SLVERR);
		rchk(8'h18, 32'h0, VTF_RESP_SLVERR);
		wchk(8'h20, 32'h0, VTF_RESP_SLVERR);
		wchk(8'h20, 32'hFFF, VTF_RESP_SLVERR);
		wchk(VTF_OFF_CTRL, 32'h0FFF0000, VTF_RESP_SLVERR);
		wchk(VTF_OFF_TIDX, 32'd64, VTF_RESP_SLVERR);
		// trunks 2 and 3, vlan 5 on access ports 0 and 6
		wchk(VTF_OFF_TRUNK, 32'h0C, VTF_RESP_OKAY);
		wchk(8'h20, 32'h5, VTF_RESP_OKAY);
		wchk(8'h38, 32'h5, VTF_RESP_OKAY);
		wchk(VTF_OFF_TIDX, 32'h1, VTF_RESP_OKAY);
		wchk(VTF_OFF_TVID, 32'h80000005, VTF_RESP_OKAY);
		wchk(VTF_OFF_TMASK, 32'h0000000E, VTF_RESP_OKAY);
		rchk(8'h20, 32'h5, VTF_RESP_OKAY);
		rchk(VTF_OFF_STATUS, 32'h00000002, VTF_RESP_OKAY);
		lk(3'h0, 1'b0, 1'b1, 12'h000, pk(0, 0, 8'h0C, 8'h4C, 12'h005));
		lk(3'h3, 1'b1, 1'b0, 12'h005, pk(0, 0, 8'h04, 8'h45, 12'h005));
		lk(3'h3, 1'b0, 1'b1, 12'h000, pk(0, 1, 8'h04, 8'hB6, 12'h001));
		lk(3'h0, 1'b1, 1'b0, 12'h007, pk(1, 0, 8'h00, 8'h00, 12'h005));
		lk(3'h3, 1'b1, 1'b0, 12'h009, pk(1, 0, 8'h00, 8'h00, 12'h009));
		rchk(VTF_OFF_STATUS, 32'h00020002, VTF_RESP_OKAY);
		wchk(VTF_OFF_TMASK, 32'h0000080E, VTF_RESP_OKAY);
		lk(3'h0, 1'b0, 1'b0, 12'h000, pk(0, 0, 8'h04, 8'h44, 12'h005));
		wchk(VTF_OFF_CTRL, 32'h00050000, VTF_RESP_OKAY);
		lk(3'h0, 1'b0, 1'b1, 12'h000, pk(0, 1, 8'h04, 8'h44, 12'h005));
		wchk(VTF_OFF_CTRL, 32'h00010001, VTF_RESP_OKAY);
		rchk(VTF_OFF_CTRL, 32'h00010001, VTF_RESP_OKAY);
		lk(3'h0, 1'b1, 1'b1, 12'h005, pk(0, 1, 8'hFE, 8'hFE, 12'h005));
		// port mode: port 0 leaves every group and must be dropped
		wchk(VTF_OFF_TIDX, 32'h0, VTF_RESP_OKAY);
		wchk(VTF_OFF_TMASK, 32'h00FE0000, VTF_RESP_OKAY);
		// only lane 2 strobed: mode bit and upper vid nibble keep their value
		wstrb <= 4'h4;
		wchk(VTF_OFF_CTRL, 32'h00FF0000, VTF_RESP_OKAY);
		wstrb <= 4'hF;
		rchk(VTF_OFF_CTRL, 32'h00FF0001, VTF_RESP_OKAY);
		rchk(VTF_OFF_TMASK, 32'h00FE0000, VTF_RESP_OKAY);
		lk(3'h0, 1'b1, 1'b1, 12'h005, pk(1, 0, 8'h00, 8'h00, 12'h005));
		// second reset starts on a clock edge, then back-to-back random lookups
		@(posedge clk);
		do_reset();
		for (int i = 0; i < 42; i++) begin
			@(posedge clk);
			if (i < 40) begin
				seed = xs(seed);
				send <= 1'b1;
				s_port <= seed[2:0];
				s_tagged <= seed[3];
				s_mgmt <= seed[6];
				s_vid <= seed[5] ? 12'h001 : seed[27:16];
				exp_q[i] = exp_def(seed[2:0], seed[3], seed[6],
					seed[5] ? 12'h001 : seed[27:16]);
			end else begin
				send <= 1'b0;
			end
			#1;
			if (i >= 2) begin
				check({res_valid ? 2'b01 : 2'b00, res_drop, res_mgmt, res_tag, res_fwd,
					res_vid}, exp_q[i - 2]);
			end
		end
		tally_and_finish();
	end
endmodule
